// ===== core/lbeh_pkg.sv
package lbeh_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes and bus answers.
  localparam int         LBEH_NRX        = 8;
  localparam int         LBEH_AW         = 8;
  localparam int         LBEH_NEV        = 4;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Function selector codes.
  localparam logic [15:0] FN_OFF         = 16'h003E;
  localparam logic [15:0] FN_AND         = 16'h0592;
  localparam logic [15:0] FN_NAND        = 16'h0593;
  localparam logic [15:0] FN_EQ          = 16'h059D;
  localparam logic [15:0] FN_NEQ         = 16'h059E;
  localparam logic [15:0] FN_OR          = 16'h05A2;
  localparam logic [15:0] FN_NOR         = 16'h05A3;
  localparam logic [15:0] FN_LATCH       = 16'h05A4;
  localparam logic [15:0] FN_RSFF        = 16'h0667;

  ////////////////////////////////////////////////////////////////////////////
  // Error policy codes and readback codes.
  localparam logic [15:0] EP_TRUE_GOOD   = 16'h05C4;
  localparam logic [15:0] EP_TRUE_BAD    = 16'h05C5;
  localparam logic [15:0] EP_FALSE_GOOD  = 16'h05C6;
  localparam logic [15:0] EP_FALSE_BAD   = 16'h05C7;
  localparam logic [15:0] RB_OFF         = 16'h003E;
  localparam logic [15:0] RB_ON          = 16'h003F;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets; receivers A..H sit at A_RXBASE + 4 * index.
  localparam logic [7:0] A_FUNC          = 8'h00;
  localparam logic [7:0] A_POLICY        = 8'h04;
  localparam logic [7:0] A_OUTVAL        = 8'h08;
  localparam logic [7:0] A_OUTERR        = 8'h0C;
  localparam logic [7:0] A_STATUS        = 8'h10;
  localparam logic [7:0] A_CLEAR         = 8'h14;
  localparam logic [7:0] A_ENABLE        = 8'h18;
  localparam logic [7:0] A_CONN          = 8'h1C;
  localparam logic [7:0] A_RXBASE        = 8'h20;
  localparam logic [7:0] A_RXLAST        = 8'h3C;

  ////////////////////////////////////////////////////////////////////////////
  // Event bit positions in status, clear and enable.
  localparam int EV_RISE                 = 0;
  localparam int EV_FALL                 = 1;
  localparam int EV_ERR                  = 2;
  localparam int EV_RXERR                = 3;

  typedef struct packed {
    logic [LBEH_NRX-1:0] val;
    logic [LBEH_NRX-1:0] err;
    logic [LBEH_NRX-1:0] conn;
  } lbeh_rx_t;

  typedef struct packed {
    logic val;
    logic err;
  } lbeh_tx_t;

  typedef struct packed {
    logic [15:0]          func;
    logic [15:0]          policy;
    lbeh_tx_t             tx;
    logic [LBEH_NEV-1:0]  status;
    logic [LBEH_NEV-1:0]  enable;
    logic                 irq;
    logic                 awready;
    logic                 wready;
    logic                 aw_held;
    logic                 w_held;
    logic [LBEH_AW-1:0]   awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } lbeh_state_t;

endpackage : lbeh_pkg

// ===== core/lbeh_logic.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1 - Error policy: four codes, default false-bad.
// RQ2 - Unresolvable input error raises output error.
// RQ3 - Off drives false, no error, always.
// RQ4 - Latch follows IN when HOLD off/errored.
// RQ5 - Latch holds IN state captured at HOLD.
// RQ6 - RS: SET error at false keeps false.
// RQ7 - RS: SET error at true keeps true.
// RQ8 - RS: RST error at false keeps false.
// RQ9 - RS: RST error at true keeps true.
// RQ10 - Combinational: decided result ignores errors, else policy.
// RQ11 - Output error reaches every transmitter consumer.
// RQ12 - Receiver A..H readback: 62 off, 63 on.
// RQ13 - Transmitter readback: 62 off, 63 on.
// RQ14 - Unconnected receivers excluded from evaluation.
// RQ15 - Function codes as listed, off is 62.
// RQ16 - Latch follows IN, freezes while HOLD on.
// RQ17 - RS: RST forces off, SET turns on.
// RQ18 - Output registered per clock, reset false-good.
module lbeh_logic
  import lbeh_pkg::*;
(
  // Clock and reset.
  input  wire logic               CLK_SYS,
  input  wire logic               NRST,
  // Receivers from other blocks, same clock.
  input  wire lbeh_rx_t           RX,
  // Transmitter and interrupt.
  output logic                    TX_VAL,
  output logic                    TX_ERR,
  output logic                    IRQ,
  // AXI4-Lite write channels.
  input  wire logic [LBEH_AW-1:0] S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output logic [1:0]              S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  // AXI4-Lite read channels.
  input  wire logic [LBEH_AW-1:0] S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output logic [31:0]             S_AXI_RDATA,
  output logic [1:0]              S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY
);

  lbeh_state_t          st;
  lbeh_state_t          next_st;
  logic [LBEH_NRX-1:0]  good_t;
  logic [LBEH_NRX-1:0]  good_f;
  logic [LBEH_NRX-1:0]  bad;
  logic                 all_good;
  logic                 any_conn;
  logic                 dec_and;
  logic                 dec_or;
  logic                 dec_eq;
  logic                 comb_fn;
  logic                 decided;
  logic                 raw_val;
  logic                 undecided;
  logic                 in_val;
  logic                 in_err;
  logic                 hold_good_on;
  logic                 set_good_on;
  logic                 rst_good_on;
  logic [LBEH_NEV-1:0]  events;
  logic [LBEH_NEV-1:0]  clr_mask;
  logic [LBEH_AW-1:0]   wa;
  logic [LBEH_AW-1:0]   ra;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    next_st = st;
    // Only connected receivers take part in the evaluation.
    good_t   = RX.conn & ~RX.err & RX.val;          // see RQ14
    good_f   = RX.conn & ~RX.err & ~RX.val;
    bad      = RX.conn & RX.err;
    all_good = (bad == '0);
    any_conn = |RX.conn;
    // A result is decided when good inputs alone fix it.
    dec_and  = (|good_f) | all_good;                 // see RQ10
    dec_or   = (|good_t) | all_good;
    dec_eq   = ((|good_t) & (|good_f)) | all_good;
    // Latch and flip-flop use the bottom two receivers, 0 and 1; unconnected reads off.
    in_val       = RX.conn[0] & RX.val[0];
    in_err       = RX.conn[0] & RX.err[0];
    hold_good_on = RX.conn[1] & ~RX.err[1] & RX.val[1];
    set_good_on  = good_t[0];
    rst_good_on  = good_t[1];
    comb_fn = 1'b1;
    decided = 1'b1;
    raw_val = 1'b0;
    case (st.func)                                   // see RQ15
      FN_AND: begin
        decided = dec_and;
        raw_val = ~(|good_f);
      end
      FN_NAND: begin
        decided = dec_and;
        raw_val = |good_f;
      end
      FN_OR: begin
        decided = dec_or;
        raw_val = |good_t;
      end
      FN_NOR: begin
        decided = dec_or;
        raw_val = ~(|good_t);
      end
      FN_EQ: begin
        decided = dec_eq;
        raw_val = ~((|good_t) & (|good_f));
      end
      FN_NEQ: begin
        decided = dec_eq;
        raw_val = (|good_t) & (|good_f);
      end
      default: begin
        comb_fn = 1'b0;
      end
    endcase
    undecided = comb_fn & any_conn & ~decided;       // see RQ2
    case (st.func)
      FN_LATCH: begin
        if (!hold_good_on) begin
          // HOLD off or in error: follow IN, value and error.
          next_st.tx.val = in_val;                   // see RQ4
          next_st.tx.err = in_err;                   // see RQ16
        end
        // HOLD on and good: the register keeps what IN had.   see RQ5
      end
      FN_RSFF: begin
        // Errored SET or RST has no effect; the output never errs.
        next_st.tx.err = 1'b0;                       // see RQ6 see RQ7 see RQ8 see RQ9
        if (rst_good_on) begin
          next_st.tx.val = 1'b0;                     // see RQ17
        end else if (set_good_on) begin
          next_st.tx.val = 1'b1;
        end
      end
      default: begin
        if (undecided) begin
          next_st.tx.val = (st.policy == EP_TRUE_GOOD) || (st.policy == EP_TRUE_BAD);
          next_st.tx.err = (st.policy == EP_TRUE_BAD) || (st.policy == EP_FALSE_BAD); // see RQ1
        end else if (comb_fn && any_conn) begin
          next_st.tx.val = raw_val;                  // see RQ10
          next_st.tx.err = 1'b0;
        end else begin
          // Off, unknown code or nothing connected.
          next_st.tx.val = 1'b0;                     // see RQ3
          next_st.tx.err = 1'b0;
        end
      end
    endcase

    // Write path: address and data are taken in either order.
    clr_mask = '0;
    if (st.bvalid && S_AXI_BREADY) begin
      next_st.bvalid = 1'b0;
    end
    if (S_AXI_AWVALID && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = S_AXI_WDATA;
      next_st.wstrb  = S_AXI_WSTRB;
    end
    wa = {next_st.awaddr[LBEH_AW-1:2], 2'b00};
    if (next_st.aw_held && next_st.w_held && !next_st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = RESP_OKAY;
      case (wa)
        A_FUNC: begin
          if (next_st.wstrb[0]) next_st.func[7:0] = next_st.wdata[7:0];
          if (next_st.wstrb[1]) next_st.func[15:8] = next_st.wdata[15:8];
        end
        A_POLICY: begin
          if (next_st.wstrb[0]) next_st.policy[7:0] = next_st.wdata[7:0];
          if (next_st.wstrb[1]) next_st.policy[15:8] = next_st.wdata[15:8];
        end
        A_CLEAR: begin
          if (next_st.wstrb[0]) clr_mask = next_st.wdata[LBEH_NEV-1:0];
        end
        A_ENABLE: begin
          if (next_st.wstrb[0]) next_st.enable = next_st.wdata[LBEH_NEV-1:0];
        end
        A_OUTVAL, A_OUTERR, A_STATUS, A_CONN: begin
          next_st.bresp = RESP_OKAY;
        end
        default: begin
          if (wa < A_RXBASE || wa > A_RXLAST) next_st.bresp = RESP_SLVERR;
        end
      endcase
    end
    next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
    next_st.wready  = ~next_st.w_held & ~next_st.bvalid;

    // Read path.
    if (st.rvalid && S_AXI_RREADY) begin
      next_st.rvalid = 1'b0;
    end
    ra = {S_AXI_ARADDR[LBEH_AW-1:2], 2'b00};
    if (S_AXI_ARVALID && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      next_st.rdata  = '0;
      case (ra)
        A_FUNC:   next_st.rdata[15:0] = st.func;
        A_POLICY: next_st.rdata[15:0] = st.policy;
        A_OUTVAL: next_st.rdata[15:0] = st.tx.val ? RB_ON : RB_OFF;   // see RQ13
        A_OUTERR: next_st.rdata[0] = st.tx.err;
        A_STATUS: next_st.rdata[LBEH_NEV-1:0] = st.status;
        A_CLEAR:  next_st.rdata = '0;
        A_ENABLE: next_st.rdata[LBEH_NEV-1:0] = st.enable;
        A_CONN:   next_st.rdata[LBEH_NRX-1:0] = RX.conn;
        default: begin
          if (ra >= A_RXBASE && ra <= A_RXLAST) begin
            next_st.rdata[15:0] = RX.val[ra[4:2]] ? RB_ON : RB_OFF;  // see RQ12
          end else begin
            next_st.rresp = RESP_SLVERR;
          end
        end
      endcase
    end
    next_st.arready = ~next_st.rvalid;

    // Sticky events; a new event wins over a clear in the same cycle.
    events           = '0;
    events[EV_RISE]  = next_st.tx.val & ~st.tx.val;
    events[EV_FALL]  = ~next_st.tx.val & st.tx.val;
    events[EV_ERR]   = next_st.tx.err & ~st.tx.err;
    events[EV_RXERR] = ~all_good;
    next_st.status   = (st.status & ~clr_mask) | events;
    next_st.irq      = |(next_st.status & next_st.enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      st        <= '0;                               // see RQ18
      st.func   <= FN_OFF;
      st.policy <= EP_FALSE_BAD;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register.
  assign TX_VAL        = st.tx.val;
  assign TX_ERR        = st.tx.err;                  // see RQ11
  assign IRQ           = st.irq;
  assign S_AXI_AWREADY = st.awready;
  assign S_AXI_WREADY  = st.wready;
  assign S_AXI_BRESP   = st.bresp;
  assign S_AXI_BVALID  = st.bvalid;
  assign S_AXI_ARREADY = st.arready;
  assign S_AXI_RDATA   = st.rdata;
  assign S_AXI_RRESP   = st.rresp;
  assign S_AXI_RVALID  = st.rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  property p_off_clean;
    (st.func == FN_OFF) |=> (!TX_VAL && !TX_ERR);
  endproperty
  a_off_clean: assert property (p_off_clean) else $error("off mode output not clean"); // see RQ3

  property p_rs_no_err;
    (st.func == FN_RSFF) |=> !TX_ERR;
  endproperty
  a_rs_no_err: assert property (p_rs_no_err) else $error("flip-flop output has error"); // see RQ7

  property p_rs_clear_wins;
    (st.func == FN_RSFF && rst_good_on) |=> !TX_VAL;
  endproperty
  a_rs_clear_wins: assert property (p_rs_clear_wins) else $error("clear did not win"); // see RQ17

  property p_rs_err_keeps;
    (st.func == FN_RSFF && !rst_good_on && !set_good_on) |=> $stable(TX_VAL);
  endproperty
  a_rs_err_keeps: assert property (p_rs_err_keeps) else $error("flip-flop lost state"); // see RQ9

  property p_latch_follow;
    (st.func == FN_LATCH && !hold_good_on)
      |=> (TX_VAL == $past(in_val)) && (TX_ERR == $past(in_err));
  endproperty
  a_latch_follow: assert property (p_latch_follow) else $error("latch did not follow"); // see RQ4

  property p_latch_hold;
    (st.func == FN_LATCH && hold_good_on) |=> $stable(TX_VAL) && $stable(TX_ERR);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch did not hold"); // see RQ5

  property p_policy;
    undecided && (st.policy == EP_FALSE_BAD) |=> (!TX_VAL && TX_ERR);
  endproperty
  a_policy: assert property (p_policy) else $error("policy not applied"); // see RQ2

  property p_decided_clean;
    (comb_fn && any_conn && decided) |=> !TX_ERR;
  endproperty
  a_decided_clean: assert property (p_decided_clean) else $error("decided result erred"); // see RQ10

  property p_outval_read;
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == A_OUTVAL)
      |=> S_AXI_RVALID && (S_AXI_RDATA[15:0] == ($past(TX_VAL) ? RB_ON : RB_OFF));
  endproperty
  a_outval_read: assert property (p_outval_read) else $error("bad output readback"); // see RQ13

  property p_bvalid_hold;
    (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

  property p_rvalid_hold;
    (S_AXI_RVALID && !S_AXI_RREADY)
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read response dropped");

  property p_ep_tg;
    undecided && (st.policy == EP_TRUE_GOOD) |=> (TX_VAL && !TX_ERR);
  endproperty
  a_ep_tg: assert property (p_ep_tg) else $error("true-good policy not applied"); // see RQ1

  property p_ep_tb;
    undecided && (st.policy == EP_TRUE_BAD) |=> (TX_VAL && TX_ERR);
  endproperty
  a_ep_tb: assert property (p_ep_tb) else $error("true-bad policy not applied"); // see RQ1

  property p_ep_fg;
    undecided && (st.policy == EP_FALSE_GOOD) |=> (!TX_VAL && !TX_ERR);
  endproperty
  a_ep_fg: assert property (p_ep_fg) else $error("false-good policy not applied"); // see RQ1

  property p_rs_set_on;
    (st.func == FN_RSFF && set_good_on && !rst_good_on) |=> TX_VAL;
  endproperty
  a_rs_set_on: assert property (p_rs_set_on) else $error("set ignored"); // see RQ17

  property p_rx_readback;
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR >= A_RXBASE && S_AXI_ARADDR <= A_RXLAST)
      |=> (S_AXI_RDATA == {16'h0000, RB_ON}) || (S_AXI_RDATA == {16'h0000, RB_OFF});
  endproperty
  a_rx_readback: assert property (p_rx_readback) else $error("bad input readback"); // see RQ12

  property p_outerr_read;
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == A_OUTERR)
      |=> S_AXI_RVALID && (S_AXI_RDATA == {31'h0, $past(TX_ERR)});
  endproperty
  a_outerr_read: assert property (p_outerr_read) else $error("bad error readback"); // see RQ11

  c_policy_used: cover property (undecided ##1 TX_ERR);
  c_latch_held:  cover property ((st.func == FN_LATCH && hold_good_on) [*3]);
  c_rs_set:      cover property (st.func == FN_RSFF && set_good_on ##1 TX_VAL);
  c_irq:         cover property ($rose(IRQ));

endmodule : lbeh_logic
`default_nettype wire

// ===== verification/lbeh_rx_src.sv
`timescale 1ns/1ps
`default_nettype none
module lbeh_rx_src
  import lbeh_pkg::*;
(
  // Clock and reset.
  input  wire logic     CLK_SYS,
  input  wire logic     NRST,
  // Receiver state that the bench asks the sources to show.
  input  wire lbeh_rx_t WANT,
  // Receivers toward the logic block.
  output var  lbeh_rx_t RX
);
  logic [LBEH_NRX-1:0] junk;

  // Unconnected receivers carry no meaning, so they show a pattern that changes every cycle.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      junk <= 8'h5A;
    end else begin
      junk <= junk + 8'h3B;
    end
  end

  assign RX = {(WANT.val & WANT.conn) | (junk & ~WANT.conn),
               (WANT.err & WANT.conn) | (~junk & ~WANT.conn),
               WANT.conn};
endmodule : lbeh_rx_src
`default_nettype wire

// ===== verification/test_logic_block_error_handling.sv
`timescale 1ns/1ps
`default_nettype none
module test_logic_block_error_handling
  import lbeh_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        nrst    = 1'b0;
  lbeh_rx_t    rx_want = '0;
  lbeh_rx_t    rx;
  logic        tx_val, tx_err, irq, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [15:0] seed    = 16'h0012;
  int          failures    = 0;
  int          checks_done = 0;

  always #50 clk_sys = ~clk_sys;

  lbeh_rx_src src (.CLK_SYS(clk_sys), .NRST(nrst), .WANT(rx_want), .RX(rx));

  lbeh_logic dut (
    .CLK_SYS(clk_sys), .NRST(nrst), .RX(rx), .TX_VAL(tx_val), .TX_ERR(tx_err), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  // Expected {value, error} of a combinational function.
  function automatic logic [1:0] exp_comb(input logic [15:0] f, input logic [15:0] p,
                                          input lbeh_rx_t r);
    logic [7:0] gv, gf;
    logic       bad, dec, v;
    gv  = r.val & r.conn & ~r.err;
    gf  = ~r.val & r.conn & ~r.err;
    bad = |(r.conn & r.err);
    v   = (f == FN_AND || f == FN_NAND) ? ~|gf : (f == FN_OR || f == FN_NOR) ? |gv : ~(|gv & |gf);
    dec = (f == FN_AND || f == FN_NAND) ? |gf : (f == FN_OR || f == FN_NOR) ? |gv : |gv & |gf;
    if (r.conn == 8'h00) return 2'h0;
    if (bad && !dec) return {p == EP_TRUE_GOOD || p == EP_TRUE_BAD, p == EP_TRUE_BAD || p == EP_FALSE_BAD};
    return {v ^ (f == FN_NAND || f == FN_NOR || f == FN_NEQ), 1'b0};
  endfunction : exp_comb

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  // The response is accepted one cycle late, so the slave must hold it meanwhile.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
    @(posedge clk_sys);
    bready <= 1'b1;
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("write response", {30'h0, bresp}, {30'h0, RESP_OKAY});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge clk_sys);
    rready <= 1'b1;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : axi_rd

  // Presents receivers and lets them reach the registered transmitter.
  task automatic apply(input logic [7:0] v, input logic [7:0] e, input logic [7:0] c);
    rx_want <= {v, e, c};
    repeat (3) @(posedge clk_sys);
  endtask : apply

  task automatic run_seq(input logic [15:0] f, input logic [5:0] tab[$]);
    axi_wr(A_FUNC, {16'h0000, f});
    foreach (tab[i]) begin
      apply({6'h00, tab[i][5:4]}, {6'h00, tab[i][3:2]}, 8'h03);
      check("sequential tx", {tx_val, tx_err}, tab[i][1:0]);
    end
  endtask : run_seq

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] fn_tab[6] = '{FN_AND, FN_NAND, FN_EQ, FN_NEQ, FN_OR, FN_NOR};
    logic [15:0] ep_tab[4] = '{EP_TRUE_GOOD, EP_TRUE_BAD, EP_FALSE_GOOD, EP_FALSE_BAD};
    logic [15:0] f, p, a, b, c;
    logic [31:0] d;
    logic [1:0]  r, e;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 2; i++) begin
      axi_rd(A_FUNC, d, r);
      check("function", d, {16'h0000, FN_OFF});
      axi_rd(A_POLICY, d, r);
      check("policy", d, {16'h0000, EP_FALSE_BAD});
      axi_rd(A_OUTVAL, d, r);
      check("output readback", d, {16'h0000, RB_OFF});
      axi_rd(8'hF0, d, r);
      check("unmapped response", {30'h0, r}, {30'h0, RESP_SLVERR});
      if (i == 0) begin
        axi_wr(A_POLICY, {16'h0000, EP_TRUE_BAD});
        apply(8'hFF, 8'hFF, 8'hFF);
        check("off tx", {tx_val, tx_err}, 2'h0);
        apply(8'h01, 8'h00, 8'h01);
        axi_wr(A_FUNC, {16'h0000, FN_OR});
        repeat (2) @(posedge clk_sys);
        check("tx before reset", tx_val, 1'b1);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("tx in reset", {tx_val, tx_err}, 2'h0);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
      end
    end
    $display("test reset and off done");
    for (int k = 0; k < 150; k++) begin
      f = fn_tab[rnd() % 6];
      p = ep_tab[rnd() % 4];
      a = rnd();
      b = rnd();
      c = (k % 16 == 0) ? 16'h0000 : (k % 16 == 1) ? 16'hFFFF : rnd();
      if (k % 16 == 1) b = 16'h0000;
      axi_wr(A_FUNC, {16'h0000, f});
      axi_wr(A_POLICY, {16'h0000, p});
      apply(a[7:0], a[15:8] & b[7:0], c[7:0]);
      e = exp_comb(f, p, {a[7:0], a[15:8] & b[7:0], c[7:0]});
      check("combinational tx", {tx_val, tx_err}, e);
      axi_rd(A_OUTVAL, d, r);
      check("output readback", d, {16'h0000, e[1] ? RB_ON : RB_OFF});
      axi_rd(A_OUTERR, d, r);
      check("output error readback", d, {31'h0, e[0]});
      axi_rd(A_CONN, d, r);
      check("connected mask", d, {24'h0, c[7:0]});
      axi_rd(A_RXBASE + 8'(4 * (k % 8)), d, r);
      if (c[k % 8]) check("receiver readback", d, {16'h0000, a[k % 8] ? RB_ON : RB_OFF});
    end
    $display("test combinational done");
    run_seq(FN_LATCH, '{6'h17, 6'h37, 6'h23, 6'h28, 6'h00});
    run_seq(FN_RSFF, '{6'h20, 6'h14, 6'h12, 6'h16, 6'h34, 6'h28, 6'h3A, 6'h2A, 6'h30});
    $display("test latch and flip-flop done");
    axi_wr(A_FUNC, {16'h0000, FN_OR});
    apply(8'h00, 8'h00, 8'h01);
    axi_wr(A_CLEAR, 32'h0000_000F);
    axi_wr(A_ENABLE, 32'h0000_0001);
    @(posedge clk_sys);
    check("irq idle", irq, 1'b0);
    apply(8'h01, 8'h00, 8'h01);
    check("irq raised", irq, 1'b1);
    axi_rd(A_STATUS, d, r);
    check("status", d, 32'h0000_0001);
    axi_wr(A_ENABLE, 32'h0000_0000);
    @(posedge clk_sys);
    check("irq masked", irq, 1'b0);
    axi_wr(A_ENABLE, 32'h0000_0001);
    @(posedge clk_sys);
    check("irq unmasked", irq, 1'b1);
    axi_wr(A_CLEAR, 32'h0000_0001);
    @(posedge clk_sys);
    check("irq cleared", irq, 1'b0);
    $display("test interrupt done");
    stop_test();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    failures++;
    stop_test();
  end
endmodule : test_logic_block_error_handling
`default_nettype wire
